//--- verilog/sac_pkg.sv
/*
 * Shared constants, state type and result decode for the serial ADC
 * conversion interface.
 * Assumes a 40 MHz system clock; all cycle counts but CLEAR_CYC derive from it.
 */
package sac_pkg;
    // Widths
    localparam int ADC_BITS = 10;
    localparam int ADDR_BITS = 4;
    // System clock period
    localparam int SYS_PERIOD_NS = 25;
    // Select must hold this long before it counts (least time, round up)
    localparam int CS_HOLD_NS = 1425;
    localparam int CS_HOLD_CYC = (CS_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    // Conversion time (longest time, round down)
    localparam int CONV_TIME_NS = 21000;
    localparam int CONV_CYC = CONV_TIME_NS / SYS_PERIOD_NS;
    // Cycles per approximation step
    localparam int BIT_CYC = CONV_CYC / (ADC_BITS + 1);
    // Abort window after the tenth falling edge (longest time, round down)
    localparam int ABORT_NS = 9000;
    localparam int ABORT_CYC = ABORT_NS / SYS_PERIOD_NS;
    // Same window seen at the filtered select: two sync flops, hold filter, edge detect
    localparam int ABORT_ACC_CYC = ABORT_CYC + CS_HOLD_CYC + 3;
    // Cycles the link is held cleared after a conversion ends
    localparam logic [2:0] CLEAR_CYC = 3'h4;
    // Link edge counts
    localparam logic [4:0] ADDR_RISES = 5'h04;
    localparam logic [4:0] ACQ_FIRST_FALL = 5'h04;
    localparam logic [4:0] TENTH_FALL = 5'h0A;
    localparam logic [4:0] LONG_RISE = 5'h0B;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    // Self-test addresses and codes
    localparam logic [3:0] ST_MID_ADDR = 4'hB;
    localparam logic [3:0] ST_LOW_ADDR = 4'hC;
    localparam logic [3:0] ST_HIGH_ADDR = 4'hD;
    localparam logic [9:0] ST_MID_CODE = 10'h200;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_FULL = 10'h3FF;
    // First trial code of the approximation
    localparam logic [9:0] SAR_START = 10'h200;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_CONV = 2'b01,
        SAC_DONE = 2'b10
    } sac_state_t;

    // Self-test addresses replace the approximation result
    function automatic logic [9:0] sac_result(input logic [3:0] addr,
                                              input logic [9:0] sar);
        case (addr)
            ST_MID_ADDR: return ST_MID_CODE;
            ST_LOW_ADDR: return CODE_ZERO;
            ST_HIGH_ADDR: return CODE_FULL;
            default: return sar;
        endcase
    endfunction : sac_result
endpackage : sac_pkg

//--- verilog/sac_link_if.sv
/*
 * Signals between the conversion core and the shift-clock link logic.
 * Core side lives on sys_clk, link side on the host shift clock.
 */
`timescale 1ns/10ps
interface sac_link_if;
    // Async clear of the link logic, from a core flop
    logic linkClear;
    // Result word, changes only while the link does not read it
    logic [9:0] resultWord;
    // Shifted-in address
    logic [3:0] address;
    // Level: tenth falling edge seen in this frame
    logic tenthSeen;
    // Level: acquisition window open
    logic sampling;
    // Level: eleventh rising edge seen
    logic longFrame;
    // Current serial bit, xored with the word's top bit
    logic linkBit;

    modport core (output linkClear, resultWord,
                  input address, tenthSeen, sampling, longFrame, linkBit);
    modport link (input linkClear, resultWord,
                  output address, tenthSeen, sampling, longFrame, linkBit);
endinterface : sac_link_if

//--- verilog/sac_cs_filter.sv
/*
 * Chip select synchroniser and hold filter.
 * Assumes chipSelectN is an asynchronous pin; runs on sys_clk.
 */
`timescale 1ns/10ps
module sac_cs_filter (
    // Clock and reset
    input logic sys_clk,
    input logic reset,
    // Select pin
    input logic chipSelectN,
    // Synchronised and accepted levels
    output logic csSyncN,
    output logic csAcceptN
);
    logic csS1_q; // First sync stage
    logic csS2_q; // Second sync stage
    logic accept_q; // Accepted select level
    logic [5:0] holdCnt_q; // Cycles the new level has held

    // Two-stage synchroniser
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            csS1_q <= 1'b1;
            csS2_q <= 1'b1;
        end else begin
            csS1_q <= chipSelectN;
            csS2_q <= csS1_q;
        end
    end

    // Accept a new level only after it holds long enough
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            holdCnt_q <= 6'h00;
            accept_q <= 1'b1;
        end else if (csS2_q == accept_q) begin
            holdCnt_q <= 6'h00; // Glitch gone, restart
        end else if (holdCnt_q == 6'(sac_pkg::CS_HOLD_CYC - 1)) begin
            accept_q <= csS2_q;
            holdCnt_q <= 6'h00;
        end else begin
            holdCnt_q <= holdCnt_q + 6'h01;
        end
    end

    assign csSyncN = csS2_q;
    assign csAcceptN = accept_q;

    cs_hold_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $changed(accept_q) |-> $past(holdCnt_q) == 6'(sac_pkg::CS_HOLD_CYC - 1))
        else $error("select accepted before hold time");
endmodule : sac_cs_filter

//--- verilog/sac_link_shifter.sv
/*
 * Shift-clock side of the serial port: address in, result out, edge counts.
 * Assumes ioClk is the host shift clock; linkClear is a glitch-free flop
 * from the core, released only while the host holds the clock still.
 */
`timescale 1ns/10ps
module sac_link_shifter (
    // Link clock and address pin
    input logic ioClk,
    input logic addressIn,
    // Core side
    sac_link_if.link lk
);
    logic [4:0] riseCnt_q; // Rising edges this frame
    logic [4:0] riseCnt_d;
    logic [4:0] fallCnt_q; // Falling edges this frame
    logic [4:0] fallCnt_d;
    logic [3:0] addrSh_q; // Address shifter
    logic longFrame_q;
    logic tenthSeen_q;
    logic sampling_q;
    logic linkBit_q;

    // Next edge counts; a full sixteen-clock frame wraps on its own
    always_comb begin
        riseCnt_d = (riseCnt_q == sac_pkg::FRAME_LEN) ? 5'h01 : riseCnt_q + 5'h01;
        fallCnt_d = (fallCnt_q == sac_pkg::FRAME_LEN - 5'h01) ? 5'h00 : fallCnt_q + 5'h01;
    end

    // Rising edges: address in, most significant bit first
    always_ff @(posedge ioClk or posedge lk.linkClear) begin
        if (lk.linkClear) begin
            riseCnt_q <= 5'h00;
            addrSh_q <= 4'h0;
            longFrame_q <= 1'b0;
        end else begin
            riseCnt_q <= riseCnt_d;
            if (riseCnt_d <= sac_pkg::ADDR_RISES) begin
                addrSh_q <= {addrSh_q[2:0], addressIn};
            end
            longFrame_q <= riseCnt_d >= sac_pkg::LONG_RISE;
        end
    end

    // Falling edges: result out, acquisition window, tenth-edge mark
    always_ff @(negedge ioClk or posedge lk.linkClear) begin
        if (lk.linkClear) begin
            fallCnt_q <= 5'h00;
            tenthSeen_q <= 1'b0;
            sampling_q <= 1'b0;
            linkBit_q <= 1'b0; // Zero means the top bit
        end else begin
            fallCnt_q <= fallCnt_d;
            tenthSeen_q <= fallCnt_d >= sac_pkg::TENTH_FALL;
            sampling_q <= (fallCnt_d >= sac_pkg::ACQ_FIRST_FALL)
                && (fallCnt_d < sac_pkg::TENTH_FALL);
            if (fallCnt_d < sac_pkg::TENTH_FALL) begin
                linkBit_q <= lk.resultWord[4'(sac_pkg::ADC_BITS - 1) - fallCnt_d[3:0]]
                    ^ lk.resultWord[9];
            end else begin
                linkBit_q <= lk.resultWord[9]; // Padding reads as zero
            end
        end
    end

    assign lk.address = addrSh_q;
    assign lk.tenthSeen = tenthSeen_q;
    assign lk.sampling = sampling_q;
    assign lk.longFrame = longFrame_q;
    assign lk.linkBit = linkBit_q;

    acq_window_a: assert property (
        @(negedge ioClk) disable iff (lk.linkClear)
        $rose(sampling_q) |-> sampling_q[*6] ##1 !sampling_q)
        else $error("acquisition window not six clock periods");
endmodule : sac_link_shifter

//--- verilog/sac_serial_adc.sv
/*
 * Serial ADC conversion interface: chip select filter, link to the host
 * shift clock, acquisition, successive approximation and end flag.
 * Assumes an external comparator and DAC: comparatorHigh is high while
 * the selected input is at or above trialCode. Pins are asynchronous.
 */
`timescale 1ns/10ps
module sac_serial_adc (
    // Clocks and reset
    input logic sys_clk,
    input logic reset,
    input logic ioClk,
    // Host serial pins
    input logic chipSelectN,
    input logic addressIn,
    output logic dataOut,
    output logic dataOutOe,
    output logic conversionDoneFlag,
    // Analog front end
    input logic comparatorHigh,
    output logic sampleEnable,
    output logic [3:0] channelSel,
    output logic [9:0] trialCode
);
    localparam int ConvBound = sac_pkg::CONV_CYC; // Flag low at most this many cycles

    sac_link_if lk (); // Link to the shift-clock logic

    logic csSyncN; // Synchronised select
    logic csAcceptN; // Filtered select
    logic csAccPrev_q; // Filtered select, last cycle
    logic tenthS1_q; // Synchronisers from the link
    logic tenthS2_q;
    logic tenthS3_q;
    logic sampS1_q;
    logic sampS2_q;
    logic longS1_q;
    logic longS2_q;
    logic bitS1_q;
    logic bitS2_q;
    logic cmpS1_q; // Comparator synchroniser
    logic cmpS2_q;
    sac_pkg::sac_state_t state_q; // Sequencer state
    logic [9:0] convCnt_q; // Cycles into the conversion
    logic [6:0] stepCnt_q; // Cycles into one approximation step
    logic [3:0] bitIdx_q; // Bit under trial
    logic sarBusy_q; // Approximation still running
    logic [9:0] trial_q; // Trial code to the DAC
    logic [9:0] result_q; // Last finished result
    logic eoc_q; // End-of-conversion flag
    logic [2:0] clrCnt_q; // Link clear hold after a conversion
    logic linkClear_q; // Link held cleared
    logic dataOut_q;
    logic dataOutOe_q;
    logic sampleEnable_q;
    logic [3:0] channelSel_q;
    logic tenthRise; // Tenth falling edge arrived
    logic csFall; // Select accepted low this cycle
    logic abortHit; // Conversion aborted this cycle
    logic convLast; // Last cycle of the conversion

    // Select filtering
    sac_cs_filter u_cs (
        .sys_clk(sys_clk),
        .reset(reset),
        .chipSelectN(chipSelectN),
        .csSyncN(csSyncN),
        .csAcceptN(csAcceptN)
    );

    // Shift-clock side
    sac_link_shifter u_link (
        .ioClk(ioClk),
        .addressIn(addressIn),
        .lk(lk.link)
    );

    assign lk.linkClear = linkClear_q;
    assign lk.resultWord = result_q;

    // Two-flop synchronisers for link levels and the comparator
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tenthS1_q <= 1'b0;
            tenthS2_q <= 1'b0;
            tenthS3_q <= 1'b0;
            sampS1_q <= 1'b0;
            sampS2_q <= 1'b0;
            longS1_q <= 1'b0;
            longS2_q <= 1'b0;
            bitS1_q <= 1'b0;
            bitS2_q <= 1'b0;
            cmpS1_q <= 1'b0;
            cmpS2_q <= 1'b0;
        end else begin
            tenthS1_q <= lk.tenthSeen;
            tenthS2_q <= tenthS1_q;
            tenthS3_q <= tenthS2_q;
            sampS1_q <= lk.sampling;
            sampS2_q <= sampS1_q;
            longS1_q <= lk.longFrame;
            longS2_q <= longS1_q;
            bitS1_q <= lk.linkBit;
            bitS2_q <= bitS1_q;
            cmpS1_q <= comparatorHigh;
            cmpS2_q <= cmpS1_q;
        end
    end

    // Edge of the accepted select
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            csAccPrev_q <= 1'b1;
        end else begin
            csAccPrev_q <= csAcceptN;
        end
    end

    // Events seen by the sequencer
    always_comb begin
        tenthRise = tenthS2_q && !tenthS3_q;
        csFall = csAccPrev_q && !csAcceptN;
        abortHit = (state_q == sac_pkg::SAC_CONV) && csFall
            && (convCnt_q < 10'(sac_pkg::ABORT_ACC_CYC));
        convLast = convCnt_q == 10'(sac_pkg::CONV_CYC - 2);
    end

    // Sequencer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= sac_pkg::SAC_IDLE;
        end else begin
            unique case (state_q)
                sac_pkg::SAC_IDLE: begin
                    if (tenthRise) begin
                        state_q <= sac_pkg::SAC_CONV;
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (abortHit) begin
                        state_q <= sac_pkg::SAC_IDLE;
                    end else if (convLast) begin
                        state_q <= sac_pkg::SAC_DONE;
                    end
                end
                sac_pkg::SAC_DONE: begin
                    state_q <= sac_pkg::SAC_IDLE;
                end
                default: begin
                    state_q <= sac_pkg::SAC_IDLE; // Unused code
                end
            endcase
        end
    end

    // Conversion timer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            convCnt_q <= 10'h000;
        end else if (state_q == sac_pkg::SAC_CONV) begin
            convCnt_q <= convCnt_q + 10'h001;
        end else begin
            convCnt_q <= 10'h000;
        end
    end

    // Successive approximation, one bit per step
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            trial_q <= sac_pkg::SAR_START;
            bitIdx_q <= 4'h9;
            stepCnt_q <= 7'h00;
            sarBusy_q <= 1'b0;
        end else if (state_q == sac_pkg::SAC_IDLE && tenthRise) begin
            trial_q <= sac_pkg::SAR_START;
            bitIdx_q <= 4'h9;
            stepCnt_q <= 7'h00;
            sarBusy_q <= 1'b1;
        end else if (state_q == sac_pkg::SAC_CONV && sarBusy_q) begin
            if (stepCnt_q == 7'(sac_pkg::BIT_CYC - 1)) begin
                stepCnt_q <= 7'h00;
                // Input below trial clears the bit; always high saturates
                if (!cmpS2_q) begin
                    trial_q[bitIdx_q] <= 1'b0;
                end
                if (bitIdx_q != 4'h0) begin
                    trial_q[bitIdx_q - 4'h1] <= 1'b1;
                    bitIdx_q <= bitIdx_q - 4'h1;
                end else begin
                    sarBusy_q <= 1'b0;
                end
            end else begin
                stepCnt_q <= stepCnt_q + 7'h01;
            end
        end
    end

    // Result register, self-test codes override the approximation
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            result_q <= sac_pkg::CODE_ZERO;
        end else if (state_q == sac_pkg::SAC_DONE) begin
            result_q <= sac_pkg::sac_result(channelSel_q, trial_q);
        end
    end

    // End-of-conversion flag
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            eoc_q <= 1'b1;
        end else if (state_q == sac_pkg::SAC_IDLE && tenthRise) begin
            eoc_q <= 1'b0;
        end else if (abortHit || state_q == sac_pkg::SAC_DONE) begin
            eoc_q <= 1'b1;
        end
    end

    // Post-conversion link clear, skipped when a long frame runs on
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clrCnt_q <= 3'h0;
        end else if (state_q == sac_pkg::SAC_DONE && !longS2_q) begin
            clrCnt_q <= sac_pkg::CLEAR_CYC;
        end else if (clrCnt_q != 3'h0) begin
            clrCnt_q <= clrCnt_q - 3'h1;
        end
    end

    // Link gating by filtered select and frame restart
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            linkClear_q <= 1'b1;
        end else begin
            linkClear_q <= csAcceptN || (clrCnt_q != 3'h0)
                || (state_q == sac_pkg::SAC_DONE && !longS2_q);
        end
    end

    // Serial output and its enable
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dataOut_q <= 1'b0;
            dataOutOe_q <= 1'b0;
        end else begin
            // Link bit is relative to the top bit, so a cleared link shows it
            dataOut_q <= bitS2_q ^ result_q[9];
            dataOutOe_q <= !csSyncN;
        end
    end

    // Acquisition control and channel latch
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sampleEnable_q <= 1'b0;
            channelSel_q <= 4'h0;
        end else begin
            sampleEnable_q <= sampS2_q;
            if (sampS2_q) begin
                channelSel_q <= lk.address;
            end
        end
    end

    assign dataOut = dataOut_q;
    assign dataOutOe = dataOutOe_q;
    assign conversionDoneFlag = eoc_q;
    assign sampleEnable = sampleEnable_q;
    assign channelSel = channelSel_q;
    assign trialCode = trial_q;

    eoc_fall_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (state_q == sac_pkg::SAC_IDLE && tenthRise) |=> !conversionDoneFlag)
        else $error("flag did not fall after tenth edge");

    conv_time_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $fell(conversionDoneFlag) |-> ##[1:ConvBound] $rose(conversionDoneFlag))
        else $error("conversion longer than allowed");

    msb_after_eoc_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        ($rose(conversionDoneFlag) && !longS2_q) |-> ##[1:3] (dataOut == result_q[9]))
        else $error("top bit late after flag rise");

    drive_on_select_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        !chipSelectN [*4] |-> dataOutOe)
        else $error("output not driven while selected");

    release_output_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        chipSelectN [*4] |-> !dataOutOe)
        else $error("output not released while deselected");

    abort_conv_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        abortHit |=> (state_q == sac_pkg::SAC_IDLE) && conversionDoneFlag
            && $stable(result_q))
        else $error("abort did not stop the conversion");

    link_gate_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        csAcceptN |=> lk.linkClear)
        else $error("link live while deselected");

    link_release_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $fell(lk.linkClear) |-> !$past(csAcceptN))
        else $error("link released before select accepted");

    selftest_mid_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (state_q == sac_pkg::SAC_DONE && channelSel_q == sac_pkg::ST_MID_ADDR)
            |=> result_q == sac_pkg::ST_MID_CODE)
        else $error("mid self-test code wrong");

    abort_c: cover property (@(posedge sys_clk) disable iff (reset) abortHit);
    done_c: cover property (@(posedge sys_clk) disable iff (reset)
        state_q == sac_pkg::SAC_DONE);
    long_frame_c: cover property (@(posedge sys_clk) disable iff (reset)
        state_q == sac_pkg::SAC_DONE && longS2_q);
endmodule : sac_serial_adc

//--- test/sac_host_model.sv
/*
 * Host serial port model: select, shift clock, address and data read.
 * Assumes sys_clk paces select changes and samples the driven data level; the shift clock runs in frames.
 */
`timescale 1ns/10ps
module sac_host_model (
    // Clock
    input wire logic sys_clk,
    // Host pins
    output logic chipSelectN,
    output logic ioClk,
    output logic addressIn,
    input wire logic dataOut,
    input wire logic dataOutOe
);
    logic lastBit = 1'b0; // Last level driven on the data pin
    logic busLevel; // Level the host sees on the data pin
    initial begin
        chipSelectN = 1'b1;
        ioClk = 1'b0;
        addressIn = 1'b0;
    end
    // A released pin shows the inverse of its last driven level
    assign busLevel = dataOutOe ? dataOut : ~lastBit;
    always @(posedge sys_clk) begin
        if (dataOutOe) lastBit <= dataOut;
    end
    // Move select, then count edges the enable lags behind
    task automatic setSelect(input logic lvl, input int hold, output int late);
        @(posedge sys_clk);
        #2 chipSelectN = lvl;
        late = 0;
        repeat (hold) begin
            #25;
            if (dataOutOe !== ~lvl) late++;
        end
    endtask : setSelect
    // One frame: address on rises, result bits read after falls
    task automatic frame(input logic [3:0] addr, input int nClk, output logic [9:0] rd);
        rd = 10'h000;
        for (int i = 0; i < nClk; i++) begin
            if (i < 10) rd[9 - i] = busLevel;
            addressIn = (i < 4) ? addr[3 - i] : 1'b0;
            #6 ioClk = 1'b1;
            #6 ioClk = 1'b0;
            #150;
        end
        addressIn = 1'b0;
    endtask : frame
endmodule : sac_host_model

//--- test/sac_serial_adc_tb.sv
/*
 * Self-checking bench for the serial ADC conversion interface.
 * Assumes an ideal comparator that tracks trialCode against analogIn.
 */
`timescale 1ns/10ps
module sac_serial_adc_tb;
    logic sysClk = 1'b0, reset = 1'b1, ioClk, chipSelectN, addressIn, comparatorHigh;
    logic dataOut, dataOutOe, conversionDoneFlag, sampleEnable;
    logic [3:0] channelSel;
    logic [9:0] trialCode, rd;
    logic [10:0] analogIn = 11'h000; // Input level, above full scale when bit 10 set
    int fails = 0, totalChecks = 0, cycles = 0, lowCnt = 0, lastLow = 0, n;
    int sampCnt = 0, lastSamp = 0; // Length of the last sample window in cycles
    always #12.5 sysClk = ~sysClk;
    // Ideal front end, slightly late after the trial code moves
    assign #2 comparatorHigh = (analogIn >= {1'b0, trialCode});
    sac_serial_adc dut (.sys_clk(sysClk), .reset(reset), .ioClk(ioClk),
        .chipSelectN(chipSelectN), .addressIn(addressIn), .dataOut(dataOut),
        .dataOutOe(dataOutOe), .conversionDoneFlag(conversionDoneFlag),
        .comparatorHigh(comparatorHigh), .sampleEnable(sampleEnable),
        .channelSel(channelSel), .trialCode(trialCode));
    sac_host_model host (.sys_clk(sysClk), .chipSelectN(chipSelectN), .ioClk(ioClk),
        .addressIn(addressIn), .dataOut(dataOut), .dataOutOe(dataOutOe));
    // Low time of the last conversion, last sample window and the run time limit
    always @(posedge sysClk) begin
        cycles <= cycles + 1;
        lowCnt <= conversionDoneFlag ? 0 : lowCnt + 1;
        if (conversionDoneFlag && lowCnt != 0) lastLow <= lowCnt;
        sampCnt <= sampleEnable ? sampCnt + 1 : 0;
        if (!sampleEnable && sampCnt != 0) lastSamp <= sampCnt;
        if (cycles == 60000) begin
            fails++;
            printVerdict();
        end
    end
    task automatic checkCode(input string what, input logic [9:0] exp, input logic [9:0] got);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : checkCode
    task automatic checkRange(input string what, input int lo, input int hi, input int got);
        totalChecks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : checkRange
    // Wait for the end flag, then the link clear time
    task automatic waitDone();
        int k = 0;
        while (conversionDoneFlag !== 1'b1 && k < 2000) begin
            @(posedge sysClk);
            #3 k++;
        end
        repeat (6) @(posedge sysClk);
    endtask : waitDone
    // Self-test codes over unframed ten-clock transfers
    task automatic testSelfTest();
        logic [3:0] addrs [4] = '{4'hB, 4'hC, 4'hD, 4'h0};
        logic [9:0] codes [3] = '{10'h200, 10'h000, 10'h3FF};
        host.frame(addrs[0], 10, rd);
        for (int i = 0; i < 3; i++) begin
            waitDone();
            host.frame(addrs[i + 1], 10, rd);
            checkCode("selftest code", codes[i], rd);
        end
        waitDone();
        $display("test selftest done");
    endtask : testSelfTest
    // Framed conversions, timing and saturation
    task automatic testConvert();
        logic [10:0] ins [3] = '{11'h2A5, 11'h7FF, 11'h000};
        logic [9:0] exps [3] = '{10'h2A5, 10'h3FF, 10'h000};
        for (int i = 0; i < 4; i++) begin
            if (i < 3) analogIn = ins[i];
            host.frame(4'h3, 10, rd);
            #90;
            if (i > 0) checkCode("result", exps[i - 1], rd);
            checkCode("flag low", 10'h000, {9'h000, conversionDoneFlag});
            checkCode("channel", 10'h003, {6'h00, channelSel});
            waitDone();
            checkRange("conversion cycles", 840, 840, lastLow);
            // Six link periods of 162 ns each, seen on the 25 ns clock
            checkRange("sample cycles", 38, 40, lastSamp);
            checkCode("trial code", exps[(i < 3) ? i : 2], trialCode);
            host.setSelect(1'b1, 70, n);
            checkRange("release lag", 0, 5, n);
            host.setSelect(1'b0, 70, n);
            checkRange("enable lag", 0, 51, n);
        end
        $display("test convert done");
    endtask : testConvert
    // Short select pulse ignored, early select fall aborts
    task automatic testAbort();
        analogIn = 11'h155;
        host.frame(4'h5, 10, rd);
        host.setSelect(1'b1, 20, n);
        host.setSelect(1'b0, 70, n);
        checkCode("flag after glitch", 10'h000, {9'h000, conversionDoneFlag});
        host.setSelect(1'b1, 70, n);
        host.setSelect(1'b0, 70, n);
        checkCode("flag after abort", 10'h001, {9'h000, conversionDoneFlag});
        // Run past where the dropped conversion would have finished
        repeat (700) @(posedge sysClk);
        host.frame(4'h5, 10, rd);
        checkCode("result kept", 10'h000, rd);
        $display("test abort done");
    endtask : testAbort
    // Unframed sixteen-clock transfers
    task automatic testLong();
        analogIn = 11'h0F0;
        waitDone();
        host.frame(4'h2, 16, rd);
        waitDone();
        host.frame(4'h2, 16, rd);
        checkCode("long frame code", 10'h0F0, rd);
        waitDone();
        $display("test long done");
    endtask : testLong
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : printVerdict
    initial begin
        repeat (5) @(posedge sysClk);
        #2 reset = 1'b0;
        host.setSelect(1'b0, 70, n);
        testSelfTest();
        testConvert();
        testAbort();
        testLong();
        printVerdict();
    end
endmodule : sac_serial_adc_tb
